/* src/lpsr_ctrl.sv */
// Purpose: controller end: refresh scheduling and self-refresh entry/exit
// Assumes: user logic keeps banks idle when banks_idle_i is high
// Notes:   refresh window is fixed-phase, started at reset release
module lpsr_ctrl
    import lpsr_pkg::*;
#(
    parameter int TREFW_P  = TREFW_CYC,
    parameter int REF_R    = REF_MIN_R,
    parameter int TCKESR_P = TCKESR_CYC,
    parameter int TXSR_P   = TXSR_CYC,
    parameter int TRFCPB_P = TRFCPB_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    lpsr_if.ctrl      mem,
    input  wire logic banks_idle_i,
    input  wire logic burst_mode_i,
    input  wire logic perbank_i,
    input  wire logic sref_req_i,
    input  wire logic sref_exit_i,
    output logic      ck_stop_o,
    output logic      in_sref_o,
    output logic      cmd_ready_o,
    output logic      ref_o,
    output logic      deficit_o,
    output logic      burst_mode_o
);
    localparam int WIN_W = $clog2(TREFW_P + 1);
    localparam int REF_W = $clog2(REF_R + 2);
    localparam int TI_W  = $clog2(TREFI_CYC + 1);
    localparam int BW_W  = $clog2(TREFBW_CYC + 1);
    lpsr_cst_e        state, next_state;
    logic [TIM_W-1:0] tim, next_tim, gap;
    logic [WIN_W-1:0] win_cnt;
    logic [TI_W-1:0]  trefi_cnt, sub_cnt;
    logic [REF_W-1:0] owed, next_owed, iss_cnt, credit;
    logic [2:0]       pb_cnt, slot_ptr;
    logic [BW_W-1:0]  age [BURST_MAX];
    logic             need_ref, burst_done, next_cke;
    logic [CA_W-1:0]  next_ca;
    // scheduling conditions
    wire in_run    = (state == C_RUN);
    wire in_sr     = (state == C_SREF) || (state == C_WAKE);
    wire win_end   = (win_cnt == WIN_W'(TREFW_P - 1));
    wire trefi_end = (trefi_cnt == TI_W'(TREFI_CYC - 1));
    wire gap_ok    = (gap == '0);
    wire slot_free = (age[slot_ptr] == '0);
    wire tim_zero  = (tim == '0);
    wire ref_base  = in_run && (owed != '0) && gap_ok && banks_idle_i;
    wire issue_ab  = ref_base && !perbank_i && slot_free;
    wire issue_pb  = ref_base && perbank_i;
    wire pb_last   = (pb_cnt == 3'(PB_PER_AB - 1));
    wire ref_unit  = issue_ab || (issue_pb && pb_last);
    wire burst_fin = burst_mode_o && ref_unit && (owed == REF_W'(1));
    wire sref_go   = in_run && sref_req_i && !ref_base && (owed == '0)
                     && !need_ref && banks_idle_i && mem.cke && gap_ok
                     && (pb_cnt == '0) && (!burst_mode_o || burst_done);
    wire xsr_done  = (state == C_XSR) && tim_zero;
    wire short_win = ({1'b0, iss_cnt} + {1'b0, credit}) < (REF_W + 1)'(REF_R);
    // past the entry cycle, so the nop after entry still sees a clock edge
    wire sr_settle = (state == C_SREF) && (tim != TIM_W'(TCKESR_P - 1));
    // burst-window age of the last eight all-bank refreshes
    for (genvar g = 0; g < BURST_MAX; g++) begin : g_slot
        always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
                age[g] <= '0;
            end else if (issue_ab && (slot_ptr == 3'(g))) begin
                age[g] <= BW_W'(TREFBW_CYC - 1);
            end else if (age[g] != '0) begin
                age[g] <= age[g] - 1'b1;
            end
        end
    end
    // refresh debt: regular accrual or burst reload
    always_comb begin
        next_owed = owed;
        if (ref_unit) begin
            next_owed = owed - 1'b1;
        end
        if (!burst_mode_o && trefi_end && !in_sr && (next_owed != '1)) begin
            next_owed = next_owed + 1'b1;
        end
        if ((burst_mode_o || burst_mode_i) && win_end && !in_sr) begin
            next_owed = REF_W'(REF_R);
        end
        if (burst_mode_o && xsr_done) begin
            next_owed = REF_W'(REF_R);
        end
    end
    // self-refresh sequence
    always_comb begin
        next_state = state;
        next_tim   = tim;
        unique case (state)
            C_RUN: begin
                if (sref_go) begin
                    next_state = C_SREF;
                    next_tim   = TIM_W'(TCKESR_P - 1);
                end
            end
            C_SREF: begin
                if (!tim_zero) begin
                    next_tim   = tim - 1'b1;
                end else if (sref_exit_i) begin
                    next_state = C_WAKE;
                    next_tim   = TIM_W'(CK_STABLE_CYC - 1);
                end
            end
            C_WAKE: begin
                if (!tim_zero) begin
                    next_tim   = tim - 1'b1;
                end else begin
                    next_state = C_XSR;
                    next_tim   = TIM_W'(TXSR_P - 1);
                end
            end
            C_XSR: begin
                if (!tim_zero) begin
                    next_tim   = tim - 1'b1;
                end else begin
                    next_state = C_RUN;
                end
            end
            default: begin
                next_state = C_RUN;
                next_tim   = '0;
            end
        endcase
    end
    // link drive: nop unless refresh or entry
    always_comb begin
        next_cke  = !(in_sr || sref_go) || (next_state == C_XSR);
        next_ca   = CA_W'(CMD_NOP);
        if (sref_go) begin
            next_ca = CA_W'(CMD_REF);
        end else if (issue_ab || issue_pb) begin
            next_ca = CA_W'(CMD_REF);
            next_ca[CA_REF_AB_BIT] = issue_ab;
        end
    end
    // sequence and link registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state    <= C_RUN;
            tim      <= '0;
            mem.cke  <= 1'b0;
            mem.cs_n <= 1'b1;
            mem.ca   <= '0;
        end else begin
            state    <= next_state;
            tim      <= next_tim;
            mem.cke  <= next_cke;
            mem.cs_n <= 1'b0;
            mem.ca   <= next_ca;
        end
    end
    // refresh spacing, rotation and slot pointer
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap      <= '0;
            pb_cnt   <= '0;
            slot_ptr <= '0;
        end else if (issue_ab) begin
            gap      <= TIM_W'(TRFCAB_CYC - 1);
            slot_ptr <= slot_ptr + 1'b1;
            pb_cnt   <= '0;
        end else if (issue_pb) begin
            gap      <= TIM_W'(TRFCPB_P - 1);
            pb_cnt   <= pb_cnt + 1'b1;
        end else if (!gap_ok) begin
            gap      <= gap - 1'b1;
        end
    end
    // window accounting with self-refresh credit (rounded up)
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            win_cnt   <= '0;
            trefi_cnt <= '0;
            sub_cnt   <= '0;
            iss_cnt   <= '0;
            credit    <= '0;
        end else begin
            trefi_cnt <= trefi_end ? '0 : trefi_cnt + 1'b1;
            if (win_end) begin
                win_cnt <= '0;
                iss_cnt <= '0;
                credit  <= '0;
                sub_cnt <= '0;
            end else begin
                win_cnt <= win_cnt + 1'b1;
                if (ref_unit && (iss_cnt != '1)) begin
                    iss_cnt <= iss_cnt + 1'b1;
                end
                if (in_sr) begin
                    sub_cnt <= trefi_end ? '0 : sub_cnt + 1'b1;
                    if ((sub_cnt == '0) && (credit != '1)) begin
                        credit <= credit + 1'b1;
                    end
                end
            end
        end
    end
    // debt, mode, and post-exit refresh obligation
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            owed         <= '0;
            burst_mode_o <= 1'b0;
            burst_done   <= 1'b0;
            need_ref     <= 1'b0;
        end else begin
            owed <= next_owed;
            if (burst_fin && !burst_mode_i) begin
                burst_mode_o <= 1'b0;
            end else if (win_end && burst_mode_i && !in_sr) begin
                burst_mode_o <= 1'b1;
            end
            if (burst_fin) begin
                burst_done <= 1'b1;
            end else if (ref_unit || sref_go || win_end) begin
                burst_done <= 1'b0;
            end
            if (xsr_done) begin
                need_ref <= 1'b1;
            end else if (ref_unit) begin
                need_ref <= 1'b0;
            end
        end
    end
    // registered status outputs
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ck_stop_o   <= 1'b0;
            in_sref_o   <= 1'b0;
            cmd_ready_o <= 1'b0;
            ref_o       <= 1'b0;
            deficit_o   <= 1'b0;
        end else begin
            ck_stop_o   <= sr_settle && (next_state == C_SREF);
            in_sref_o   <= (next_state != C_RUN);
            cmd_ready_o <= (next_state == C_RUN) && !sref_go && !ref_base;
            ref_o       <= issue_ab || issue_pb;
            deficit_o   <= win_end && short_win;
        end
    end
endmodule : lpsr_ctrl

/* src/lpsr_pkg.sv */
// Purpose: shared constants and types for the refresh / self-refresh link
// Assumes: one 250 MHz clock shared by controller and memory end
// Notes:   counts derived from times; plain defaults where no figure is known
package lpsr_pkg;
    // link widths and encodings
    localparam int          CA_W          = 10;
    localparam int          CA_REF_AB_BIT = 3;           // high: all-bank, low: per-bank
    localparam logic [2:0]  CMD_REF       = 3'h4;        // ca2 high, ca1 low, ca0 low
    localparam logic [2:0]  CMD_NOP       = 3'h7;
    localparam logic [2:0]  TEMP_STAT_NOM = 3'h3;        // temperature_status_register for 32 ms
    localparam int          BANKS         = 8;
    localparam int          PB_PER_AB     = 8;           // per-bank commands per full rotation
    localparam int          BURST_MAX     = 8;           // all-bank refreshes per burst window

    // times in their own units
    localparam int          CLK_NS        = 4;
    localparam int          TRFCAB_NS     = 130;
    localparam int          TREFI_NS      = 7800;
    localparam int          TREFBW_NS     = 4 * BURST_MAX * TRFCAB_NS;
    localparam int          TREFW_MS      = 32;
    localparam int          TCKESR_NS     = 15;          // plain default
    localparam int          TXSR_NS       = 140;         // plain default
    localparam int          TRFCPB_NS     = 60;          // plain default
    localparam int          REF_MIN_R     = 4096;

    // cycle counts: least times round up, longest round down
    localparam int          TRFCAB_CYC    = (TRFCAB_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TRFCPB_CYC    = (TRFCPB_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TREFBW_CYC    = (TREFBW_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TREFI_CYC     = TREFI_NS / CLK_NS;
    localparam int          TREFW_CYC     = (TREFW_MS * 1000000) / CLK_NS;
    localparam int          TCKESR_CYC    = (TCKESR_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TXSR_CYC      = (TXSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CK_STABLE_CYC = 2;
    localparam int          TIM_W         = 12;

    // controller states
    typedef enum logic [3:0] {
        C_RUN  = 4'b0001,
        C_SREF = 4'b0010,
        C_WAKE = 4'b0100,
        C_XSR  = 4'b1000
    } lpsr_cst_e;

    // memory-end states
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_SREF = 3'b010,
        D_XSR  = 3'b100
    } lpsr_dst_e;
endpackage : lpsr_pkg

/* src/lpsr_if.sv */
// Purpose: command/address link between controller and memory end
// Assumes: both ends clocked by the same clock
// Notes:   clock stop is signalled beside the link by the controller
interface lpsr_if
    import lpsr_pkg::*;
();
    logic            cke;
    logic            cs_n;
    logic [CA_W-1:0] ca;

    modport ctrl (output cke, output cs_n, output ca);
    modport dev  (input cke, input cs_n, input ca);
endinterface : lpsr_if

/* src/lpsr_dev.sv */
// Purpose: memory end: refresh decode, self refresh with internal timer
// Assumes: link inputs come from logic on the same clock
// Notes:   internal refresh pulses stand for the gated internal clock domain
module lpsr_dev
    import lpsr_pkg::*;
#(
    parameter int TREFI_P = TREFI_CYC,
    parameter int TXSR_P  = TXSR_CYC
) (
    input  wire logic  clk_sys_i,
    input  wire logic  rstn_i,
    lpsr_if.dev        mem,
    output logic       sref_o,
    output logic       xsr_o,
    output logic       int_ref_o,
    output logic       refab_o,
    output logic       refpb_o,
    output logic [2:0] pb_bank_o,
    output logic       pb_rot_o,
    output logic       xsr_viol_o
);
    lpsr_dst_e        state;
    lpsr_dst_e        next_state;
    logic             cke_d;
    logic [TIM_W-1:0] tim;
    logic [TIM_W-1:0] next_tim;
    logic [2:0]       bank;

    // command decode on the link
    wire cmd_ref   = !mem.cs_n && (mem.ca[2:0] == CMD_REF);
    wire cmd_ab    = mem.ca[CA_REF_AB_BIT];
    wire in_idle   = (state == D_IDLE);
    wire entry_hit = in_idle && cke_d && !mem.cke && cmd_ref;
    wire ab_hit    = in_idle && cke_d && mem.cke && cmd_ref && cmd_ab;
    wire pb_hit    = in_idle && cke_d && mem.cke && cmd_ref && !cmd_ab;
    wire tim_zero  = (tim == '0);
    wire exit_hit  = (state == D_SREF) && mem.cke;
    wire xsr_bad   = (state == D_XSR) && (!mem.cke ||
                     (!mem.cs_n && (mem.ca[2:0] != CMD_NOP)));
    wire iref_hit  = (state == D_SREF) && !mem.cke && tim_zero;

    // state and timer steering
    always_comb begin
        next_state = state;
        next_tim   = tim;
        unique case (state)
            D_IDLE: begin
                if (entry_hit) begin
                    next_state = D_SREF;
                    next_tim   = '0;
                end
            end
            D_SREF: begin
                if (exit_hit) begin
                    next_state = D_XSR;
                    next_tim   = TIM_W'(TXSR_P - 1);
                end else if (tim_zero) begin
                    next_tim   = TIM_W'(TREFI_P - 1);
                end else begin
                    next_tim   = tim - 1'b1;
                end
            end
            D_XSR: begin
                if (tim_zero) begin
                    next_state = D_IDLE;
                end else begin
                    next_tim   = tim - 1'b1;
                end
            end
            default: begin
                next_state = D_IDLE;
                next_tim   = '0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= D_IDLE;
            tim   <= '0;
            cke_d <= 1'b0;
        end else begin
            state <= next_state;
            tim   <= next_tim;
            cke_d <= mem.cke;
        end
    end

    // per-bank rotation counter, cleared by all-bank refresh and exit
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bank <= '0;
        end else if (ab_hit || exit_hit) begin
            bank <= '0;
        end else if (pb_hit) begin
            bank <= bank + 1'b1;
        end
    end

    // registered user-side outputs
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sref_o     <= 1'b0;
            xsr_o      <= 1'b0;
            int_ref_o  <= 1'b0;
            refab_o    <= 1'b0;
            refpb_o    <= 1'b0;
            pb_bank_o  <= '0;
            pb_rot_o   <= 1'b0;
            xsr_viol_o <= 1'b0;
        end else begin
            sref_o     <= (next_state == D_SREF);
            xsr_o      <= (next_state == D_XSR);
            int_ref_o  <= iref_hit;
            refab_o    <= ab_hit;
            refpb_o    <= pb_hit;
            pb_bank_o  <= bank;
            pb_rot_o   <= pb_hit && (bank == 3'(PB_PER_AB - 1));
            xsr_viol_o <= xsr_bad;
        end
    end
endmodule : lpsr_dev

/* verification/lpsr_checker.sv */
// Purpose: link checks between controller end and memory end
// Assumes: one clock, asynchronous active-low reset
// Notes:   counters stand in for the long timing figures
module lpsr_checker
    import lpsr_pkg::*;
#(
    parameter int TXSR_P = TXSR_CYC
) (
    input wire logic            clk_sys_i,
    input wire logic            rstn_i,
    input wire logic            cke,
    input wire logic            cs_n,
    input wire logic [CA_W-1:0] ca
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BW_MIN = TREFBW_CYC - 1;

    // command decode on the link
    wire ref_c  = !cs_n && cke && (ca[2:0] == CMD_REF);
    wire ref_ab = ref_c && ca[CA_REF_AB_BIT];
    wire ref_pb = ref_c && !ca[CA_REF_AB_BIT];
    wire nop_c  = cs_n || (ca[2:0] == CMD_NOP);
    logic       cke_d;
    logic       sr_seen;
    logic       need_ref;
    logic [2:0] pb_cnt;
    logic [2:0] ab_wp;
    int         ab_n;
    int         xcnt;
    int         gap;
    int         cyc;
    int         ab_ts [8];
    wire exit_c = sr_seen && cke && !cke_d;

    // exit interval, spacing and refresh bookkeeping
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {cke_d, sr_seen, need_ref, pb_cnt, ab_wp} <= '0;
            {ab_n, xcnt, gap, cyc} <= '0;
        end else begin
            cke_d    <= cke;
            cyc      <= cyc + 1;
            sr_seen  <= sr_seen || (!cke && cke_d);
            xcnt     <= exit_c ? TXSR_P - 1 : (xcnt != 0 ? xcnt - 1 : 0);
            gap      <= ref_ab ? TRFCAB_CYC - 1 : (gap != 0 ? gap - 1 : 0);
            need_ref <= exit_c || (need_ref && !ref_ab && !(ref_pb && pb_cnt == 3'h7));
            pb_cnt   <= (ref_ab || exit_c) ? 3'h0 : pb_cnt + 3'(ref_pb);
            if (ref_ab) begin
                ab_ts[ab_wp] <= cyc;
                ab_wp        <= ab_wp + 3'h1;
                ab_n         <= (ab_n < 8) ? ab_n + 1 : 8;
            end
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence s_entry;
        $fell(cke) ##0 (!cs_n && ca[2:0] == CMD_REF);
    endsequence
    sequence s_low_hold;
        !cke [*5];
    endsequence

    a_entry_code: assert property ($fell(cke) |-> !cs_n && ca[2:0] == CMD_REF)
        else $error("cke dropped without entry command");
    a_entry_nop: assert property (s_entry |=> nop_c)
        else $error("no nop after entry");
    a_sref_resid: assert property (s_entry |-> s_low_hold)
        else $error("self refresh left too early");
    a_xsr_nops: assert property (xcnt != 0 |-> cke && nop_c)
        else $error("command or cke low inside exit interval");
    a_exit_nop: assert property (exit_c |-> nop_c)
        else $error("exit edge carries a command");
    a_ref_after_exit: assert property ($fell(cke) |-> !need_ref)
        else $error("entry without refresh since last exit");
    a_burst_limit: assert property (ref_ab && ab_n == 8 |-> cyc - ab_ts[ab_wp] >= BW_MIN)
        else $error("more than eight all-bank refreshes in burst window");
    a_ref_gap: assert property (ref_c |-> gap == 0)
        else $error("refresh inside all-bank cycle time");
endmodule : lpsr_checker

/* verification/lpsr_tb_top.sv */
// Purpose: drives both ends joined by the link and judges the outcome
// Assumes: short refresh window and small count for simulation
// Notes:   inputs change 1 ns after the rising edge
module lpsr_tb_top
    import lpsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TREFW = 20000;
    logic       clk_sys_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       banks_idle_i = 1'b1;
    logic       burst_mode_i = 1'b0;
    logic       perbank_i = 1'b0;
    logic       sref_req_i = 1'b0;
    logic       sref_exit_i = 1'b0;
    logic       ck_stop_o, in_sref_o, cmd_ready_o, ref_o, deficit_o, burst_mode_o;
    logic       sref_o, xsr_o, int_ref_o, refab_o, refpb_o, pb_rot_o, xsr_viol_o;
    logic [2:0] pb_bank_o;
    int         err_count = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         bad = 0;

    // the two ends and the link checker
    lpsr_if lpsr_if_i ();
    lpsr_ctrl #(.TREFW_P(TREFW), .REF_R(8)) lpsr_ctrl_i (.clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i), .mem(lpsr_if_i.ctrl), .banks_idle_i(banks_idle_i),
        .burst_mode_i(burst_mode_i), .perbank_i(perbank_i), .sref_req_i(sref_req_i),
        .sref_exit_i(sref_exit_i), .ck_stop_o(ck_stop_o), .in_sref_o(in_sref_o),
        .cmd_ready_o(cmd_ready_o), .ref_o(ref_o), .deficit_o(deficit_o),
        .burst_mode_o(burst_mode_o));
    lpsr_dev lpsr_dev_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mem(lpsr_if_i.dev),
        .sref_o(sref_o), .xsr_o(xsr_o), .int_ref_o(int_ref_o), .refab_o(refab_o),
        .refpb_o(refpb_o), .pb_bank_o(pb_bank_o), .pb_rot_o(pb_rot_o),
        .xsr_viol_o(xsr_viol_o));
    lpsr_checker #(.TXSR_P(TXSR_CYC)) lpsr_checker_i (.clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i), .cke(lpsr_if_i.cke), .cs_n(lpsr_if_i.cs_n), .ca(lpsr_if_i.ca));

    always #2 clk_sys_i = ~clk_sys_i;

    // hang limit, window shortfalls and exit-interval faults
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (rstn_i && (deficit_o === 1'b1 || xsr_viol_o === 1'b1)) bad <= bad + 1;
        if (cyc == 90000) begin
            err_count = err_count + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic wait_for(ref logic sig, input int lim, input string what);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
        check(what, {31'h0, sig}, 32'h1);
    endtask : wait_for

    task automatic count_ev(ref logic sig, input int n, output int c);
        c = 0;
        repeat (n) begin
            step(1);
            c += int'(sig === 1'b1);
        end
    endtask : count_ev

    task automatic t_regular();
        int c;
        count_ev(refab_o, 3 * TREFI_CYC, c);
        check("regular rate", 32'(c >= 2 && c <= 4), 32'h1);
        $display("test regular done");
    endtask : t_regular

    task automatic t_perbank();
        perbank_i = 1'b1;
        wait_for(ref_o, 3 * TREFI_CYC, "refresh strobe");
        for (int i = 0; i < PB_PER_AB; i++) begin
            wait_for(refpb_o, 3 * TREFI_CYC, "per-bank refresh");
            check("bank order", 32'(pb_bank_o), 32'(i));
            check("rotation end", 32'(pb_rot_o), 32'(i == 7));
            step(1);
        end
        $display("test perbank done");
    endtask : t_perbank

    task automatic sref_once(input logic want_ref);
        int c;
        logic got;
        got = 1'b0;
        c = 0;
        sref_req_i = 1'b1;
        while (sref_o !== 1'b1 && c < 10000) begin
            got |= (refab_o === 1'b1);
            step(1);
            c++;
        end
        check("self refresh entered", 32'(sref_o), 32'h1);
        check("controller in self refresh", 32'(in_sref_o), 32'h1);
        check("clock kept for nop edge", 32'(ck_stop_o), 32'h0);
        if (want_ref) check("refresh between exits", 32'(got), 32'h1);
        count_ev(int_ref_o, 8, c);
        check("internal refresh", 32'(c >= 1), 32'h1);
        check("clock stop allowed", 32'(ck_stop_o), 32'h1);
        check("commands held back", 32'(cmd_ready_o), 32'h0);
        sref_req_i = 1'b0;
        sref_exit_i = 1'b1;
        wait_for(xsr_o, 200, "exit interval start");
        c = 0;
        while (xsr_o === 1'b1 && c < 200) begin
            c++;
            step(1);
        end
        check("exit interval length", 32'(c), 32'(TXSR_CYC));
        check("controller back in run", 32'(in_sref_o), 32'h0);
        sref_exit_i = 1'b0;
    endtask : sref_once

    task automatic t_sref();
        perbank_i = 1'b0;
        sref_once(1'b0);
        sref_once(1'b1);
        check("no shortfall or exit fault", 32'(bad), 32'h0);
        $display("test sref done");
    endtask : t_sref

    task automatic t_burst();
        int c;
        burst_mode_i = 1'b1;
        // the pattern only switches at a window end; count one full window after it
        wait_for(burst_mode_o, TREFW, "burst mode start");
        count_ev(refab_o, TREFW, c);
        check("burst mode active", 32'(burst_mode_o), 32'h1);
        check("burst count", 32'(c), 32'h8);
        step(2);
        check("no shortfall at window ends", 32'(bad), 32'h0);
        $display("test burst done");
    endtask : t_burst

    // reset, then the scenarios in order
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        step(2);
        t_regular();
        t_perbank();
        t_sref();
        t_burst();
        test_done();
    end
endmodule : lpsr_tb_top
